// *** shared/rio_consts.vh ***
// Purpose: constants of the relay io conditioning block
// Assumes: 100 MHz system clock, AXI4-Lite byte addresses
// Notes: definitions only
`ifndef RIO_CONSTS_VH
`define RIO_CONSTS_VH

// ----------------------------------------
// timing
// ----------------------------------------
`define RIO_CLK_PERIOD_NS 10
`define RIO_TICK_MS 1
// one ms of RIO_CLK_PERIOD_NS cycles, sized to the 17-bit tick counter
`define RIO_TICK_CYCLES 17'd100000
`define RIO_DEB_T1_MS 7'd20
`define RIO_DEB_T2_MS 7'd50
`define RIO_DEB_T3_MS 7'd100

// ----------------------------------------
// debounce selection codes
// ----------------------------------------
`define RIO_DEB_NONE 2'h0
`define RIO_DEB_20 2'h1
`define RIO_DEB_50 2'h2
`define RIO_DEB_100 2'h3

// ----------------------------------------
// register offsets
// ----------------------------------------
`define RIO_OFF_DEBOUNCE 8'h00
`define RIO_OFF_INVERT 8'h04
`define RIO_OFF_IN_STATE 8'h08
`define RIO_OFF_RELAY_STATE 8'h0c
`define RIO_OFF_ACK 8'h10
`define RIO_RELAY_REGION 2'h1
`define RIO_RELAY_SEL 2'h0
`define RIO_RELAY_CFG 2'h1
`define RIO_RELAY_HOLD 2'h2

// ----------------------------------------
// relay config fields
// ----------------------------------------
`define RIO_CFG_EN_LSB 0
`define RIO_CFG_INV_LSB 8
`define RIO_CFG_COLL_INV 16
`define RIO_CFG_MODE 17
`define RIO_CFG_LATCH 18

// ----------------------------------------
// reset values and bus answers
// ----------------------------------------
`define RIO_RST_DEBOUNCE 16'h0000
`define RIO_RST_INVERT 8'h00
`define RIO_RST_SEL 28'h0000000
`define RIO_RST_CFG 19'h00000
`define RIO_RST_HOLD 16'h0000
`define RIO_RESP_OKAY 2'h0
`define RIO_RESP_SLVERR 2'h2

`endif

// *** core/rio_debounce.v ***
// Purpose: debounce and optional inversion of one digital input
// Assumes: raw input synchronous to CLK, one-cycle ms tick
// Notes: stable level needs limit+1 ticks so at least limit ms pass
`include "rio_consts.vh"
`timescale 1ns/100ps
`default_nettype none

module rio_debounce (
    input wire clk,
    input wire rst,
    input wire tick,
    input wire raw,
    input wire [1:0] deb_sel,
    input wire inv,
    output reg cond
);

reg stable;
reg [6:0] cnt;
reg [6:0] limit;

always @*
begin
    case (deb_sel)
        `RIO_DEB_20: limit = `RIO_DEB_T1_MS;
        `RIO_DEB_50: limit = `RIO_DEB_T2_MS;
        `RIO_DEB_100: limit = `RIO_DEB_T3_MS;
        default: limit = 7'h00;
    endcase
end

always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        stable <= 1'b0;
        cnt <= 7'h00;
        cond <= 1'b0;
    end
    else
    begin
        if (raw == stable)
            cnt <= 7'h00;
        else if (deb_sel == `RIO_DEB_NONE)
            stable <= raw;
        else if (tick)
        begin
            if (cnt == limit)
            begin
                stable <= raw;
                cnt <= 7'h00;
            end
            else
                cnt <= cnt + 7'h01;
        end
        cond <= stable ^ inv;
    end
end

endmodule // rio_debounce
`default_nettype wire

// *** core/rio_relay.v ***
// Purpose: one output relay: assignment, inversion, latch, hold time
// Assumes: 16 assignable signals, one-cycle ms tick
// Notes: hold counter restarts on every change of the relay state
`include "rio_consts.vh"
`timescale 1ns/100ps
`default_nettype none

module rio_relay (
    input wire clk,
    input wire rst,
    input wire tick,
    input wire [15:0] sigs,
    input wire [27:0] sel,
    input wire [18:0] cfg,
    input wire [15:0] hold_ms,
    input wire ack,
    output reg coil,
    output reg state,
    output reg latch_q,
    output wire hold_busy
);

reg [16:0] hold_cnt;
wire [6:0] slot;
reg comb;
wire target;
genvar k;

generate
    for (k = 0; k < 7; k = k + 1)
    begin : g_slot
        assign slot[k] = cfg[`RIO_CFG_EN_LSB + k]
                         & (sigs[sel[4*k+3:4*k]] ^ cfg[`RIO_CFG_INV_LSB + k]);
    end
endgenerate

always @*
    comb = (|slot) ^ cfg[`RIO_CFG_COLL_INV];

assign hold_busy = (hold_cnt != 17'h00000);
// stored state persists even if latching is switched off later
assign target = comb | latch_q;

always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        state <= 1'b0;
        latch_q <= 1'b0;
        hold_cnt <= 17'h00000;
        coil <= 1'b0;
    end
    else
    begin
        if (cfg[`RIO_CFG_LATCH] && comb)
            latch_q <= 1'b1;
        else if (ack && !comb && !hold_busy)
            latch_q <= 1'b0;
        if (!hold_busy && target != state)
        begin
            state <= target;
            // one extra tick: the tick phase must never cut the hold short
            if (hold_ms == 16'h0000)
                hold_cnt <= 17'h00000;
            else
                hold_cnt <= {1'b0, hold_ms} + 17'h00001;
        end
        else if (tick && hold_busy)
            hold_cnt <= hold_cnt - 17'h00001;
        coil <= state ^ cfg[`RIO_CFG_MODE];
    end
end

endmodule // rio_relay
`default_nettype wire

// *** core/rio_top.v ***
// Purpose: relay io conditioning with AXI4-Lite register access
// Assumes: all pin inputs synchronous to CLK
// Notes: eight inputs, four relays, signal set = inputs then functions
// Operation
// - a changed input is taken only after staying stable for none, 20, 50, 100 ms
// - each input has an inversion setting, inactive after reset
// - eight conditioned input signals are offered to the assignment logic
// - each relay is the OR of up to seven chosen assignable signals
// - every assigned signal can be inverted before the OR
// - the combined relay state can be inverted as a whole
// - operating mode picks working current or closed circuit energizing
// - without latching the relay follows its combined assigned signals
// - with latching a set relay state is stored until acknowledged
// - acknowledge counts only once initiators are inactive and hold time expired
// - after every change the relay keeps its new state for the hold time
//
// The register offsets and the AXI4-Lite register port were decided locally.
`include "rio_consts.vh"
`timescale 1ns/100ps
`default_nettype none

module rio_top #(
    parameter [16:0] TICK_CYCLES = `RIO_TICK_CYCLES
) (
    input wire CLK,
    input wire SYS_RST,
    input wire INPUT_SIGNAL_1,
    input wire INPUT_SIGNAL_2,
    input wire INPUT_SIGNAL_3,
    input wire INPUT_SIGNAL_4,
    input wire INPUT_SIGNAL_5,
    input wire INPUT_SIGNAL_6,
    input wire INPUT_SIGNAL_7,
    input wire INPUT_SIGNAL_8,
    input wire [7:0] FUNC_SIG,
    input wire ACK_IN,
    output wire [7:0] DI_COND,
    output wire [3:0] RELAY_OUT,
    input wire [7:0] S_AXI_AWADDR,
    input wire [2:0] S_AXI_AWPROT,
    input wire S_AXI_AWVALID,
    output wire S_AXI_AWREADY,
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    output wire S_AXI_WREADY,
    output reg [1:0] S_AXI_BRESP,
    output reg S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire [7:0] S_AXI_ARADDR,
    input wire [2:0] S_AXI_ARPROT,
    input wire S_AXI_ARVALID,
    output wire S_AXI_ARREADY,
    output reg [31:0] S_AXI_RDATA,
    output reg [1:0] S_AXI_RRESP,
    output reg S_AXI_RVALID,
    input wire S_AXI_RREADY
);

// ----------------------------------------
// declarations
// ----------------------------------------
localparam [16:0] TICK_LAST = TICK_CYCLES - 17'h00001;

reg [16:0] tick_cnt;
reg tick;
reg [15:0] deb_cfg;
reg [7:0] inv_cfg;
reg [27:0] rel_sel [0:3];
reg [18:0] rel_cfg [0:3];
reg [15:0] rel_hold [0:3];
reg [3:0] ack_pulse;
reg aw_held;
reg w_held;
reg [7:0] aw_addr;
reg [31:0] w_data;
reg [3:0] w_strb;
reg wr_hit;
reg [31:0] rd_data;
reg rd_hit;
reg [31:0] wmask;
reg [31:0] old_val;
wire [31:0] new_val;
wire wr_go;
wire rd_go;
wire [7:0] raw_in;
wire [15:0] sig_set;
wire [3:0] rel_state;
wire [3:0] rel_latch;
wire [3:0] rel_busy;
wire [1:0] wr_rel;
wire [1:0] rd_rel;
wire [7:0] rd_word;
genvar i;

assign raw_in = {INPUT_SIGNAL_8, INPUT_SIGNAL_7, INPUT_SIGNAL_6, INPUT_SIGNAL_5,
                 INPUT_SIGNAL_4, INPUT_SIGNAL_3, INPUT_SIGNAL_2, INPUT_SIGNAL_1};
assign sig_set = {FUNC_SIG, DI_COND};

// ----------------------------------------
// millisecond time base
// ----------------------------------------
always @(posedge CLK or posedge SYS_RST)
begin
    if (SYS_RST)
    begin
        tick_cnt <= 17'h00000;
        tick <= 1'b0;
    end
    else if (tick_cnt == TICK_LAST)
    begin
        tick_cnt <= 17'h00000;
        tick <= 1'b1;
    end
    else
    begin
        tick_cnt <= tick_cnt + 17'h00001;
        tick <= 1'b0;
    end
end

// ----------------------------------------
// input conditioning
// ----------------------------------------
generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_in
        rio_debounce u_deb (
            .clk(CLK),
            .rst(SYS_RST),
            .tick(tick),
            .raw(raw_in[i]),
            .deb_sel(deb_cfg[2*i+1:2*i]),
            .inv(inv_cfg[i]),
            .cond(DI_COND[i])
        );
    end
endgenerate

// ----------------------------------------
// output relays
// ----------------------------------------
generate
    for (i = 0; i < 4; i = i + 1)
    begin : g_rel
        rio_relay u_rel (
            .clk(CLK),
            .rst(SYS_RST),
            .tick(tick),
            .sigs(sig_set),
            .sel(rel_sel[i]),
            .cfg(rel_cfg[i]),
            .hold_ms(rel_hold[i]),
            .ack(ack_pulse[i] | ACK_IN),
            .coil(RELAY_OUT[i]),
            .state(rel_state[i]),
            .latch_q(rel_latch[i]),
            .hold_busy(rel_busy[i])
        );
    end
endgenerate

// ----------------------------------------
// bus write channel
// ----------------------------------------
// address and data may arrive in either order; each is parked until both exist
assign S_AXI_AWREADY = ~aw_held;
assign S_AXI_WREADY = ~w_held;
assign wr_go = aw_held & w_held & ~S_AXI_BVALID;
assign wr_rel = aw_addr[5:4];

always @*
begin
    wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    wr_hit = 1'b1;
    old_val = 32'h00000000;
    if (aw_addr == `RIO_OFF_DEBOUNCE)
        old_val = {16'h0000, deb_cfg};
    else if (aw_addr == `RIO_OFF_INVERT)
        old_val = {24'h000000, inv_cfg};
    else if (aw_addr == `RIO_OFF_ACK)
        old_val = 32'h00000000;
    else if (aw_addr[7:6] == `RIO_RELAY_REGION && aw_addr[3:2] == `RIO_RELAY_SEL)
        old_val = {4'h0, rel_sel[wr_rel]};
    else if (aw_addr[7:6] == `RIO_RELAY_REGION && aw_addr[3:2] == `RIO_RELAY_CFG)
        old_val = {13'h0000, rel_cfg[wr_rel]};
    else if (aw_addr[7:6] == `RIO_RELAY_REGION && aw_addr[3:2] == `RIO_RELAY_HOLD)
        old_val = {16'h0000, rel_hold[wr_rel]};
    else
        wr_hit = 1'b0;
end

assign new_val = (old_val & ~wmask) | (w_data & wmask);

always @(posedge CLK or posedge SYS_RST)
begin
    if (SYS_RST)
    begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        aw_addr <= 8'h00;
        w_data <= 32'h00000000;
        w_strb <= 4'h0;
        S_AXI_BVALID <= 1'b0;
        S_AXI_BRESP <= `RIO_RESP_OKAY;
    end
    else
    begin
        if (S_AXI_AWVALID && !aw_held)
        begin
            aw_held <= 1'b1;
            aw_addr <= {S_AXI_AWADDR[7:2], 2'h0};
        end
        if (S_AXI_WVALID && !w_held)
        begin
            w_held <= 1'b1;
            w_data <= S_AXI_WDATA;
            w_strb <= S_AXI_WSTRB;
        end
        if (wr_go)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= wr_hit ? `RIO_RESP_OKAY : `RIO_RESP_SLVERR;
        end
        else if (S_AXI_BREADY)
            S_AXI_BVALID <= 1'b0;
    end
end

// ----------------------------------------
// configuration registers
// ----------------------------------------
generate
    for (i = 0; i < 4; i = i + 1)
    begin : g_cfg
        always @(posedge CLK or posedge SYS_RST)
        begin
            if (SYS_RST)
            begin
                rel_sel[i] <= `RIO_RST_SEL;
                rel_cfg[i] <= `RIO_RST_CFG;
                rel_hold[i] <= `RIO_RST_HOLD;
            end
            else if (wr_go && wr_hit && aw_addr[7:6] == `RIO_RELAY_REGION
                     && {30'h00000000, wr_rel} == i)
            begin
                if (aw_addr[3:2] == `RIO_RELAY_SEL)
                    rel_sel[i] <= new_val[27:0];
                else if (aw_addr[3:2] == `RIO_RELAY_CFG)
                    rel_cfg[i] <= new_val[18:0];
                else if (aw_addr[3:2] == `RIO_RELAY_HOLD)
                    rel_hold[i] <= new_val[15:0];
            end
        end
    end
endgenerate

always @(posedge CLK or posedge SYS_RST)
begin
    if (SYS_RST)
    begin
        deb_cfg <= `RIO_RST_DEBOUNCE;
        inv_cfg <= `RIO_RST_INVERT;
        ack_pulse <= 4'h0;
    end
    else
    begin
        ack_pulse <= 4'h0;
        if (wr_go && aw_addr == `RIO_OFF_DEBOUNCE)
            deb_cfg <= new_val[15:0];
        else if (wr_go && aw_addr == `RIO_OFF_INVERT)
            inv_cfg <= new_val[7:0];
        else if (wr_go && aw_addr == `RIO_OFF_ACK)
            ack_pulse <= new_val[3:0];
    end
end

// ----------------------------------------
// bus read channel
// ----------------------------------------
assign S_AXI_ARREADY = ~S_AXI_RVALID;
assign rd_go = S_AXI_ARVALID & ~S_AXI_RVALID;
assign rd_rel = S_AXI_ARADDR[5:4];
assign rd_word = {S_AXI_ARADDR[7:2], 2'h0};

always @*
begin
    rd_hit = 1'b1;
    rd_data = 32'h00000000;
    if (rd_word == `RIO_OFF_DEBOUNCE)
        rd_data = {16'h0000, deb_cfg};
    else if (rd_word == `RIO_OFF_INVERT)
        rd_data = {24'h000000, inv_cfg};
    else if (rd_word == `RIO_OFF_IN_STATE)
        rd_data = {24'h000000, DI_COND};
    else if (rd_word == `RIO_OFF_RELAY_STATE)
        rd_data = {4'h0, rel_busy, 4'h0, rel_latch, 4'h0, rel_state, 4'h0, RELAY_OUT};
    else if (rd_word == `RIO_OFF_ACK)
        rd_data = 32'h00000000;
    else if (S_AXI_ARADDR[7:6] == `RIO_RELAY_REGION && S_AXI_ARADDR[3:2] == `RIO_RELAY_SEL)
        rd_data = {4'h0, rel_sel[rd_rel]};
    else if (S_AXI_ARADDR[7:6] == `RIO_RELAY_REGION && S_AXI_ARADDR[3:2] == `RIO_RELAY_CFG)
        rd_data = {13'h0000, rel_cfg[rd_rel]};
    else if (S_AXI_ARADDR[7:6] == `RIO_RELAY_REGION && S_AXI_ARADDR[3:2] == `RIO_RELAY_HOLD)
        rd_data = {16'h0000, rel_hold[rd_rel]};
    else
        rd_hit = 1'b0;
end

always @(posedge CLK or posedge SYS_RST)
begin
    if (SYS_RST)
    begin
        S_AXI_RVALID <= 1'b0;
        S_AXI_RDATA <= 32'h00000000;
        S_AXI_RRESP <= `RIO_RESP_OKAY;
    end
    else if (rd_go)
    begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_data;
        S_AXI_RRESP <= rd_hit ? `RIO_RESP_OKAY : `RIO_RESP_SLVERR;
    end
    else if (S_AXI_RREADY)
        S_AXI_RVALID <= 1'b0;
end

endmodule // rio_top
`default_nettype wire

// *** bench/rio_field.sv ***
// Purpose: field contacts ahead of the eight digital inputs
// Assumes: levels are set by the bench just after a clock edge
// Notes: chatter flips the masked pins every cycle, a worst-case bounce
`timescale 1ns/100ps
`default_nettype none
module rio_field (
    input wire logic clk,
    input wire logic [7:0] lvl,
    input wire logic [7:0] chat,
    output logic [7:0] pins
);
    logic flip = 1'b0;
    initial pins = 8'h00;
    always @(posedge clk)
    begin
        flip <= ~flip;
        pins <= lvl ^ (chat & {8{flip}});
    end
endmodule // rio_field
`default_nettype wire

// *** bench/rio_checker.sv ***
// Purpose: port checks of rio_top
// Assumes: one clock, asynchronous active-high reset
// Notes: bound to every rio_top below the module
`timescale 1ns/100ps
`default_nettype none
module rio_checker (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic [7:0] DI_COND,
    input wire logic [3:0] RELAY_OUT,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic S_AXI_BVALID,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic S_AXI_RVALID,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic S_AXI_RREADY
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);
    a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
        && S_AXI_WREADY && !S_AXI_BVALID |=> ##1 S_AXI_BVALID) else $error("no write answer");
    a_bresp_held: assert property (S_AXI_BVALID && !S_AXI_BREADY
        |=> S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write answer dropped");
    // a new write may start while the answer stands, so only idle buses count
    a_bvalid_drop: assert property (S_AXI_BVALID && S_AXI_BREADY && !S_AXI_AWVALID
        && !S_AXI_WVALID |=> !S_AXI_BVALID) else $error("write answer stuck");
    a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY
        |=> S_AXI_RVALID) else $error("no read answer");
    a_rdata_held: assert property (S_AXI_RVALID && !S_AXI_RREADY
        |=> S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data moved");
    a_read_cause: assert property ($rose(S_AXI_RVALID) |-> $past(S_AXI_ARVALID))
        else $error("read answer without request");
    a_rvalid_drop: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
        else $error("read answer stuck");
    a_reset_clear: assert property ($fell(SYS_RST)
        |-> DI_COND == 8'h00 && RELAY_OUT == 4'h0) else $error("outputs not cleared");
    cover property (S_AXI_BVALID && S_AXI_BREADY);
    cover property (S_AXI_RVALID && S_AXI_RREADY);
    cover property ($rose(RELAY_OUT[0]));
endmodule // rio_checker
bind rio_top rio_checker rio_checker_inst (.CLK(CLK), .SYS_RST(SYS_RST),
    .DI_COND(DI_COND), .RELAY_OUT(RELAY_OUT), .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RREADY(S_AXI_RREADY));
`default_nettype wire

// *** bench/test_rio_top.sv ***
// Purpose: self-checking bench of rio_top
// Assumes: TICK_CYCLES of 10, so one ms is 10 cycles
// Notes: relay setups are random from a fixed seed
`timescale 1ns/100ps
`default_nettype none
module test_rio_top;
    localparam int MS = 10;
    logic clk = 1'b0, rst = 1'b1, ack = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, lvl = 8'h00, chat = 8'h00, func = 8'h00;
    logic [31:0] wdata = 32'h0, rdat;
    logic [27:0] sel;
    logic [18:0] cfg;
    logic [1:0] resp;
    logic [7:0] inv;
    wire [7:0] pins, di_cond;
    wire [3:0] relay_out;
    wire awready, wready, bvalid, arready, rvalid;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    int mismatches = 0, checked = 0, cycles = 0, seed = 32'hc8f68d82;
    rio_field rio_field_inst (.clk(clk), .lvl(lvl), .chat(chat), .pins(pins));
    rio_top #(.TICK_CYCLES(17'd10)) rio_top_inst (.CLK(clk), .SYS_RST(rst),
        .INPUT_SIGNAL_1(pins[0]), .INPUT_SIGNAL_2(pins[1]), .INPUT_SIGNAL_3(pins[2]),
        .INPUT_SIGNAL_4(pins[3]), .INPUT_SIGNAL_5(pins[4]), .INPUT_SIGNAL_6(pins[5]),
        .INPUT_SIGNAL_7(pins[6]), .INPUT_SIGNAL_8(pins[7]), .FUNC_SIG(func), .ACK_IN(ack),
        .DI_COND(di_cond), .RELAY_OUT(relay_out), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    initial
        forever #5 clk = ~clk;
    task automatic tally_and_finish;
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            mismatches = mismatches + 1;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked = checked + 1;
        if (seen !== exp)
        begin
            mismatches = mismatches + 1;
            $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
    endtask
    // each bus task ends one edge late so its strobes never toggle twice at once
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic pend;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        pend = 1'b1;
        while (pend)
        begin
            @(posedge clk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            if (bvalid)
            begin
                resp = bresp;
                bready <= 1'b0;
                pend = 1'b0;
            end
        end
        tk(1);
    endtask
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        @(posedge clk);
        while (!arready)
            @(posedge clk);
        arvalid <= 1'b0;
        @(posedge clk);
        while (!rvalid)
            @(posedge clk);
        rdat = rdata;
        resp = rresp;
        rready <= 1'b0;
        tk(1);
    endtask
    task automatic ackp;
        ack <= 1'b1;
        tk(1);
        ack <= 1'b0;
    endtask
    task automatic fpulse;
        func[0] <= 1'b1;
        tk(1);
        func[0] <= 1'b0;
    endtask
    function automatic int deb_ms(input int c);
        return c == 1 ? 20 : c == 2 ? 50 : 100;
    endfunction
    function automatic logic rexp(input logic [27:0] s, input logic [18:0] c,
        input logic [15:0] g);
        logic o;
        o = 1'b0;
        for (int k = 0; k < 7; k++)
            if (c[k])
                o = o | (g[s[4*k +: 4]] ^ c[8+k]);
        return o ^ c[16] ^ c[17];
    endfunction
    initial
    begin
        tk(4);
        rst <= 1'b0;
        tk(1);
        rd(8'h00);
        chk(rdat, 32'h0);
        rd(8'h44);
        chk(rdat, 32'h0);
        rd(8'h4c);
        chk(resp, 2'h2);
        wr(8'h4c, 32'h0);
        chk(resp, 2'h2);
        for (int i = 0; i < 6; i++)
        begin
            inv = 8'($random(seed));
            wr(8'h04, {24'h0, inv});
            chk(resp, 2'h0);
            lvl <= 8'($random(seed));
            tk(4);
            chk(di_cond, lvl ^ inv);
            rd(8'h08);
            chk(rdat, {24'h0, lvl ^ inv});
        end
        inv = 8'h00;
        wr(8'h04, 32'h0);
        for (int c = 1; c < 4; c++)
        begin
            wr(8'h00, 32'(c));
            chat <= 8'h01;
            tk(deb_ms(c) * MS);
            chk(di_cond[0], lvl[0]);
            chat <= 8'h00;
            lvl[0] <= ~lvl[0];
            tk(deb_ms(c) * MS - 2);
            chk(di_cond[0], !lvl[0]);
            tk(2 * MS + 2);
            chk(di_cond[0], lvl[0]);
        end
        wr(8'h00, 32'h0);
        for (int i = 0; i < 12; i++)
        begin
            sel = 28'($random(seed));
            cfg = 19'($random(seed)) & 19'h3ffff;
            wr(8'h40 + 8'(16 * (i % 4)), {4'h0, sel});
            wr(8'h44 + 8'(16 * (i % 4)), {13'h0, cfg});
            func <= 8'($random(seed));
            tk(4);
            chk(relay_out[i % 4], rexp(sel, cfg, {func, lvl}));
        end
        func <= 8'h00;
        wr(8'h40, 32'h8);
        wr(8'h48, 32'h3);
        wr(8'h44, 32'h1);
        tk(5 * MS);
        fpulse();
        tk(2 * MS + 9);
        chk(relay_out[0], 1'b1);
        tk(3 * MS);
        chk(relay_out[0], 1'b0);
        wr(8'h44, 32'h40001);
        fpulse();
        tk(2);
        ackp();
        tk(6 * MS);
        chk(relay_out[0], 1'b1);
        func[0] <= 1'b1;
        tk(3);
        wr(8'h10, 32'h1);
        func[0] <= 1'b0;
        tk(4);
        chk(relay_out[0], 1'b1);
        ackp();
        tk(4);
        chk(relay_out[0], 1'b0);
        tk(5 * MS);
        fpulse();
        tk(5 * MS);
        wr(8'h10, 32'h1);
        tk(4);
        chk(relay_out[0], 1'b0);
        rd(8'h0c);
        chk(rdat & 32'h01010101, 32'h01000000);
        tally_and_finish();
    end
endmodule // test_rio_top
`default_nettype wire
